// File: rtl/cap_regs_pkg.sv
// Constants for the host controller capability register bank
package cap_regs_pkg;
  // ==================================================================
  // Register offsets from the memory base address
  localparam logic [31:0] CAP_LEN_VER_OFS  = 32'h0000_0000;
  localparam logic [31:0] STRUCT_PARAM_OFS = 32'h0000_0004;
  // Decoded window covers both words
  localparam int          WINDOW_LSB       = 3;
  localparam int          WORD_SEL_BIT     = 2;

  // ==================================================================
  // Field layout
  localparam int CAPLEN_LSB    = 0;
  localparam int CAPLEN_W      = 8;
  localparam int CAP_RSVD_LSB  = 8;
  localparam int CAP_RSVD_W    = 8;
  localparam int VERSION_LSB   = 16;
  localparam int VERSION_W     = 16;
  localparam int HCS_LOW_W     = 16;
  localparam int HCS_RSVD_LSB  = 16;
  localparam int HCS_RSVD_W    = 16;

  // ==================================================================
  // Reset and fixed values
  localparam logic [CAPLEN_W-1:0]   CAPLEN_RESET   = 8'h20;
  localparam logic [CAP_RSVD_W-1:0] CAP_RSVD_VAL   = 8'h00;
  localparam logic [HCS_RSVD_W-1:0] HCS_RSVD_VAL   = 16'h0000;
  localparam logic [15:0]           VERSION_DFLT   = 16'h0000;
  localparam logic [31:0]           RDATA_IDLE     = 32'h0000_0000;
endpackage : cap_regs_pkg

// File: rtl/cap_dec_if.sv
// Carrier between the register bank and its address decoder
`timescale 1ns/1ps
interface cap_dec_if;
  logic [31:0] addr;
  logic [31:0] base;
  logic        hit;
  logic        sel_struct;

  modport dec  (input addr, input base, output hit, output sel_struct);
  modport user (output addr, output base, input hit, input sel_struct);
endinterface : cap_dec_if

// File: rtl/cap_addr_decode.sv
// Address decoder relative to the memory base address
`timescale 1ns/1ps
module cap_addr_decode (
  cap_dec_if.dec d
);
  import cap_regs_pkg::*;

  logic [31:0] rel;

  // ==================================================================
  // Offset from base; wrap below base falls outside the window
  assign rel          = d.addr - d.base;
  assign d.hit        = (rel[31:WINDOW_LSB] == '0);
  assign d.sel_struct = rel[WORD_SEL_BIT];
endmodule // cap_addr_decode

// File: rtl/host_capability_registers.sv
// Read-only capability registers at the head of the host controller register space
// Summary of operation
// - Offset zero decoded from base; bits 15:8 zero
// - Capability length bits 7:0, read-only, resets 0x20
// - Operational registers sit at base plus length
// - Bits 31:16 return BCD interface version
// - Offset 4 structural word, bits 31:16 zero
`timescale 1ns/1ps
module host_capability_registers #(
  parameter logic [cap_regs_pkg::VERSION_W-1:0] INTERFACE_VERSION = cap_regs_pkg::VERSION_DFLT
) (
  input  wire logic                               sys_clk,
  input  wire logic                               srst,
  input  wire logic [31:0]                        bar_base,
  input  wire logic [cap_regs_pkg::HCS_LOW_W-1:0] struct_low,
  input  wire logic                               req_valid,
  input  wire logic                               req_write,
  input  wire logic [31:0]                        req_addr,
  input  wire logic [31:0]                        req_wdata,
  output logic                                    resp_valid,
  output logic                                    resp_hit,
  output logic [31:0]                             resp_rdata,
  output logic [31:0]                             op_base
);
  import cap_regs_pkg::*;

  logic [CAPLEN_W-1:0]  capability_length_r;
  logic [HCS_LOW_W-1:0] struct_low_r;
  logic [31:0]          rdata_nxt;
  logic [31:0]          cap_word;
  logic [31:0]          struct_word;
  logic                 unused_wdata;

  cap_dec_if dec_bus ();

  // ==================================================================
  // Address decode
  assign dec_bus.addr = req_addr;
  assign dec_bus.base = bar_base;

  cap_addr_decode u_dec (
    .d (dec_bus)
  );

  // Write data has nowhere to go: every field is read-only
  assign unused_wdata = ^req_wdata;

  // ==================================================================
  // Held fields
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      capability_length_r <= CAPLEN_RESET;
    end
  end

  // Low structural fields come from the neighbouring block each cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      struct_low_r <= '0;
    end else begin
      struct_low_r <= struct_low;
    end
  end

  // ==================================================================
  // Read words
  assign cap_word    = {INTERFACE_VERSION, CAP_RSVD_VAL, capability_length_r};
  assign struct_word = {HCS_RSVD_VAL, struct_low_r};

  always_comb begin
    rdata_nxt = RDATA_IDLE;
    if (req_valid && !req_write && dec_bus.hit) begin
      rdata_nxt = dec_bus.sel_struct ? struct_word : cap_word;
    end
  end

  // ==================================================================
  // Response: one cycle after the request, writes completed silently
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resp_valid <= 1'b0;
      resp_hit   <= 1'b0;
      resp_rdata <= RDATA_IDLE;
    end else begin
      resp_valid <= req_valid;
      resp_hit   <= req_valid && dec_bus.hit;
      resp_rdata <= rdata_nxt;
    end
  end

  // Start of operational space, tracks base relocation
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      op_base <= '0;
    end else begin
      op_base <= bar_base + {{(32-CAPLEN_W){1'b0}}, capability_length_r};
    end
  end

  // ==================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_cap_read;
    req_valid && !req_write && (req_addr == bar_base + CAP_LEN_VER_OFS);
  endsequence

  sequence s_struct_read;
    req_valid && !req_write && (req_addr == bar_base + STRUCT_PARAM_OFS);
  endsequence

  property p_cap_reserved;
    s_cap_read |=> resp_hit && (resp_rdata[CAP_RSVD_LSB +: CAP_RSVD_W] == '0);
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("offset zero reserved byte not zero");

  property p_caplen;
    s_cap_read |=> resp_rdata[CAPLEN_LSB +: CAPLEN_W] == CAPLEN_RESET;
  endproperty
  a_caplen: assert property (p_caplen) else $error("capability length not 0x20");

  property p_op_base;
    1'b1 |=> op_base == $past(bar_base) + {{(32-CAPLEN_W){1'b0}}, CAPLEN_RESET};
  endproperty
  a_op_base: assert property (p_op_base) else $error("operational base not base plus length");

  property p_version;
    s_cap_read |=> resp_rdata[VERSION_LSB +: VERSION_W] == INTERFACE_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("interface version field wrong");

  property p_struct;
    s_struct_read |=> resp_hit && (resp_rdata[HCS_RSVD_LSB +: HCS_RSVD_W] == '0)
                      && (resp_rdata[HCS_LOW_W-1:0] == $past(struct_low_r));
  endproperty
  a_struct: assert property (p_struct) else $error("structural word wrong");

  property p_write_ignored;
    req_valid && req_write ##1 req_valid && !req_write && (req_addr == bar_base)
      |=> resp_rdata[CAPLEN_LSB +: CAPLEN_W] == CAPLEN_RESET && resp_hit;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write disturbed a field");

  property p_write_ack;
    req_valid && req_write |=> resp_valid && (resp_rdata == '0);
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write not acknowledged cleanly");

  property p_unmapped;
    req_valid && ((req_addr - bar_base) >= (32'h1 << WINDOW_LSB)) |=> resp_valid && !resp_hit && (resp_rdata == '0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered as hit");

  property p_no_spurious;
    !req_valid |=> !resp_valid && !resp_hit;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("response without request");

  // ==================================================================
  // Checks over the whole window, byte lanes included
  localparam logic [31:0] WINDOW_BYTES = 32'h1 << WINDOW_LSB;

  logic [31:0] chk_rel;

  // Offset of the request from the base, wrapping below it like the decoder
  assign chk_rel = req_addr - bar_base;

  sequence s_write;
    req_valid && req_write;
  endsequence

  sequence s_window_write;
    req_valid && req_write && (chk_rel < WINDOW_BYTES);
  endsequence

  sequence s_cap_lane_read;
    req_valid && !req_write && (chk_rel < STRUCT_PARAM_OFS);
  endsequence

  sequence s_struct_lane_read;
    req_valid && !req_write && (chk_rel >= STRUCT_PARAM_OFS) && (chk_rel < WINDOW_BYTES);
  endsequence

  // Reset must clear the response path even though the other checks are off during it
  property p_reset_clear;
    disable iff (1'b0)
    srst |=> !resp_valid && !resp_hit && (resp_rdata == RDATA_IDLE) && (op_base == '0)
             && (capability_length_r == CAPLEN_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left a response or wrong length");

  property p_cap_lanes;
    s_cap_lane_read |=> resp_hit && (resp_rdata == {INTERFACE_VERSION, CAP_RSVD_VAL, CAPLEN_RESET});
  endproperty
  a_cap_lanes: assert property (p_cap_lanes) else $error("offset zero word wrong on a byte lane");

  property p_struct_lanes;
    s_struct_lane_read |=> resp_hit && (resp_rdata[HCS_RSVD_LSB +: HCS_RSVD_W] == HCS_RSVD_VAL);
  endproperty
  a_struct_lanes: assert property (p_struct_lanes) else $error("structural reserved bits set on a byte lane");

  property p_write_hit;
    s_window_write |=> resp_valid && resp_hit && (resp_rdata == RDATA_IDLE);
  endproperty
  a_write_hit: assert property (p_write_hit) else $error("in-window write not completed as a hit");

  property p_access_answered;
    req_valid |=> resp_valid;
  endproperty
  a_access_answered: assert property (p_access_answered) else $error("access left without an answer");

  // Software finds the operational space from the length, so no access may move it
  property p_access_no_effect;
    req_valid |=> $stable(capability_length_r);
  endproperty
  a_access_no_effect: assert property (p_access_no_effect) else $error("access changed the length field");

  // A write straight before a structural read must not leak into the returned word
  property p_write_then_struct;
    s_write ##1 s_struct_lane_read |=> resp_hit && (resp_rdata[HCS_RSVD_LSB +: HCS_RSVD_W] == HCS_RSVD_VAL)
                                       && (resp_rdata[HCS_LOW_W-1:0] == $past(struct_low_r));
  endproperty
  a_write_then_struct: assert property (p_write_then_struct) else $error("write disturbed the structural word");

  property p_idle_quiet;
    !req_valid |=> resp_rdata == RDATA_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("read data shown without a request");
endmodule // host_capability_registers

// File: tb/tb_host_capability_registers.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module tb_host_capability_registers;
  import cap_regs_pkg::*;
  // ==================================================================
  // Signals
  localparam logic [15:0] VER = 16'h0100;
  logic        sys_clk;
  logic        srst;
  logic [31:0] bar_base;
  logic [15:0] struct_low;
  logic        req_valid;
  logic        req_write;
  logic [31:0] req_addr;
  logic [31:0] req_wdata;
  logic        resp_valid;
  logic        resp_hit;
  logic [31:0] resp_rdata;
  logic [31:0] op_base;
  logic [32:0] exp_q[$];
  int          n_fail;
  int          cmp_count;

  host_capability_registers #(.INTERFACE_VERSION(VER)) u_host_capability_registers (
    .sys_clk(sys_clk), .srst(srst), .bar_base(bar_base), .struct_low(struct_low),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_hit(resp_hit), .resp_rdata(resp_rdata), .op_base(op_base));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==================================================================
  // Tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request stays up between calls so back-to-back accesses never toggle the strobe twice
  task automatic access(input logic wr, input logic [31:0] a);
    logic [31:0] o;
    o = a - bar_base;
    exp_q.push_back({o < 8, (wr || o >= 8) ? 32'h0 :
                    (o[2] ? {HCS_RSVD_VAL, struct_low} : {VER, CAP_RSVD_VAL, CAPLEN_RESET})});
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = $urandom;
    @(negedge sys_clk);
  endtask

  task automatic idle(input string name);
    req_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({1'b0, op_base}, {1'b0, bar_base + 32'h20});
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    check({1'b0, 32'(exp_q.size())}, 33'h0);
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==================================================================
  // Response monitor
  always @(negedge sys_clk) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check({resp_hit, resp_rdata}, 33'h1_FFFF_FFFF);
      else
        check({resp_hit, resp_rdata}, exp_q.pop_front());
    end else if (resp_valid !== 1'b0) begin
      check({32'h0, resp_valid}, 33'h0);
    end
  end

  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  // ==================================================================
  // Main sequence
  initial begin
    n_fail     = 0;
    cmp_count  = 0;
    void'($urandom(32'h7C12E5E7));
    srst       = 1'b1;
    req_valid  = 1'b0;
    req_write  = 1'b0;
    req_addr   = 32'h0;
    req_wdata  = 32'h0;
    bar_base   = ($urandom & 32'h7FFF_FF00) | 32'h0000_1000;
    struct_low = 16'($urandom);
    repeat (12) @(negedge sys_clk);
    check({1'b0, op_base}, 33'h0);
    srst = 1'b0;
    idle("reset");
    access(1'b0, bar_base);
    access(1'b0, bar_base + 32'h4);
    access(1'b0, bar_base + 32'h3);
    access(1'b0, bar_base + 32'h7);
    idle("reads");
    access(1'b1, bar_base);
    access(1'b1, bar_base + 32'h4);
    access(1'b0, bar_base);
    access(1'b0, bar_base + 32'h4);
    idle("writes");
    access(1'b0, bar_base - 32'h4);
    access(1'b0, bar_base + 32'h8);
    access(1'b1, bar_base + 32'h8);
    idle("misses");
    bar_base   = ($urandom & 32'h7FFF_FFF8) | 32'h0000_1000;
    struct_low = 16'($urandom);
    idle("rebase");
    for (int i = 0; i < 40; i++)
      access(1'($urandom_range(1, 0)), bar_base - 32'h8 + $urandom_range(23, 0));
    idle("random");
    finish_test();
  end
endmodule // tb_host_capability_registers
